// file: dv/testbench.sv
// self-checking bench for the uart flow-control block
`timescale 1ns/1ns
`include "ufc_map.vh"
module testbench;
  reg        core_clk;
  reg        rst = 1'b1;
  reg        cfg_wr = 1'b0;
  reg  [3:0] cfg_sel = 4'h0;
  reg  [7:0] cfg_data = 8'h00;
  reg        iir_rd = 1'b0;
  reg  [6:0] rx_level = 7'h00;
  reg        cts_hold = 1'b0;
  reg        rx_valid = 1'b0;
  reg  [7:0] rx_data = 8'h00;
  reg        rxo_ready = 1'b0;
  reg        tx_in_valid = 1'b0;
  reg  [7:0] tx_in_data = 8'h00;
  reg        slow = 1'b0;
  reg  [7:0] b;
  wire       cts_n_pin, rts_n_q, rx_ready, rxo_valid, tx_in_ready_q;
  wire       tx_out_valid_q, tx_out_ready, irq_q;
  wire [7:0] rxo_data, tx_out_data_q, iir_q, lsr_q, msr_q, scratch_q;
  wire [7:0] got_q, n_q;
  integer    fails = 0;
  integer    checks = 0;
  integer    m;
  ufc_flow uut (
    .core_clk(core_clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
    .cfg_data(cfg_data), .iir_rd(iir_rd), .msr_rd(1'b0),
    .rx_level(rx_level), .cts_n_pin(cts_n_pin), .modem_n_pin(3'h7),
    .rts_n_q(rts_n_q), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .rxo_valid(rxo_valid), .rxo_ready(rxo_ready),
    .rxo_data(rxo_data), .tx_in_valid(tx_in_valid),
    .tx_in_ready_q(tx_in_ready_q), .tx_in_data(tx_in_data),
    .tx_out_valid_q(tx_out_valid_q), .tx_out_ready(tx_out_ready),
    .tx_out_data_q(tx_out_data_q), .irq_q(irq_q), .iir_q(iir_q),
    .lsr_q(lsr_q), .msr_q(msr_q), .scratch_q(scratch_q));
  ufc_remote u_remote (
    .core_clk(core_clk), .rst(rst), .slow(slow), .cts_hold(cts_hold),
    .tx_out_valid_q(tx_out_valid_q), .tx_out_data_q(tx_out_data_q),
    .tx_out_ready(tx_out_ready), .cts_n_pin(cts_n_pin),
    .got_q(got_q), .n_q(n_q));
  // 50 mhz core clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task cmp8(input [63:0] nm, input [7:0] e, input [7:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task cmp1(input [63:0] nm, input e, input g);
    cmp8(nm, {7'h0, e}, {7'h0, g});
  endtask
  task tick(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  task conclude;
    begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task bail;
    begin
      fails = fails + 1;
      conclude;
    end
  endtask
  task cfg(input [3:0] s, input [7:0] d);
    begin
      @(posedge core_clk);
      cfg_wr <= 1'b1;
      cfg_sel <= s;
      cfg_data <= d;
      @(posedge core_clk);
      cfg_wr <= 1'b0;
    end
  endtask
  // one received char, held until the edge that takes it
  task rxc(input [7:0] c);
    integer i;
    begin
      @(posedge core_clk);
      rx_valid <= 1'b1;
      rx_data <= c;
      for (i = 0; rx_ready !== 1'b1 || i == 0; i = i + 1) begin
        if (i > 40) bail;
        @(posedge core_clk);
      end
      rx_valid <= 1'b0;
    end
  endtask
  // one byte into the transmit path, then check the far side got it
  task sendc(input [7:0] d);
    integer i;
    begin
      b = n_q;
      @(posedge core_clk);
      tx_in_valid <= 1'b1;
      tx_in_data <= d;
      for (i = 0; tx_in_ready_q !== 1'b1 || i == 0; i = i + 1) begin
        if (i > 40) bail;
        @(posedge core_clk);
      end
      tx_in_valid <= 1'b0;
      waitn(b + 8'h01);
      cmp8("tx", d, got_q);
    end
  endtask
  task waitn(input [7:0] k);
    integer i;
    for (i = 0; n_q !== k; i = i + 1) begin
      if (i > 80) bail;
      @(posedge core_clk);
    end
  endtask
  // a pending byte must not be taken for twelve cycles
  task nordy;
    integer k;
    reg     s;
    begin
      s = 1'b0;
      for (k = 0; k < 12; k = k + 1) begin
        @(posedge core_clk);
        if (tx_in_ready_q === 1'b1) s = 1'b1;
      end
      cmp1("tx_rdy", 1'b0, s);
    end
  endtask
  task pop;
    begin
      @(posedge core_clk);
      rxo_ready <= 1'b1;
      @(posedge core_clk);
      rxo_ready <= 1'b0;
      tick(2);
    end
  endtask
  task lvl(input [6:0] v, input e);
    begin
      rx_level <= v;
      tick(4);
      cmp1("rts_n", e, rts_n_q);
    end
  endtask
  // reset values, then a mid-run reset that spares scratch
  task s_reset;
    begin
      tick(4);
      cmp8("iir", `UFC_RST_IIR, iir_q);
      cmp8("lsr", `UFC_RST_LSR, lsr_q);
      cmp8("msr", 8'h11, msr_q);
      cmp1("rts_n", 1'b1, rts_n_q);
      cfg(`UFC_SEL_SCR, 8'h5a);
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      tick(2);
      cmp8("scratch", 8'h5a, scratch_q);
    end
  endtask
  // hysteresis: halt 6, resume 2
  task s_rts;
    begin
      cfg(`UFC_SEL_MCR, 8'h02);
      tick(4);
      cmp1("rts_n", 1'b0, rts_n_q);
      cfg(`UFC_SEL_TCR, 8'h26);
      cfg(`UFC_SEL_EFR, 8'h40);
      lvl(7'h05, 1'b0);
      lvl(7'h06, 1'b1);
      lvl(7'h03, 1'b1);
      lvl(7'h02, 1'b0);
      cfg(`UFC_SEL_EFR, 8'h00);
      cfg(`UFC_SEL_MCR, 8'h00);
    end
  endtask
  // fill the store until it refuses, then drain in order
  task s_fifo;
    begin
      for (m = 0; m < 4; m = m + 1) rxc(8'h40 + m[7:0]);
      tick(2);
      cmp1("rx_rdy", 1'b0, rx_ready);
      for (m = 0; m < 4; m = m + 1) begin
        cmp8("rxo", 8'h40 + m[7:0], rxo_data);
        pop;
      end
      cmp1("rxo_v", 1'b0, rxo_valid);
    end
  endtask
  task s_xoff;
    begin
      cfg(`UFC_SEL_RESUME_CHAR_FIRST, 8'h11);
      cfg(`UFC_SEL_HALT_CHAR_FIRST, 8'h13);
      cfg(`UFC_SEL_IER, 8'h20);
      cfg(`UFC_SEL_EFR, 8'h02);
      rxc(8'h13);
      tick(3);
      cmp8("iir", `UFC_IIR_XOFF, iir_q);
      cmp1("irq", 1'b1, irq_q);
      cmp1("rxo_v", 1'b0, rxo_valid);
      tx_in_valid <= 1'b1;
      tx_in_data <= 8'h55;
      nordy;
      tx_in_valid <= 1'b0;
      rxc(8'h11);
      tick(3);
      cmp8("iir", `UFC_RST_IIR, iir_q);
      cmp1("irq", 1'b0, irq_q);
      sendc(8'h55);
    end
  endtask
  task s_spec;
    begin
      cfg(`UFC_SEL_HALT_CHAR_SECOND, 8'h17);
      cfg(`UFC_SEL_EFR, 8'h20);
      rxc(8'h17);
      tick(3);
      cmp8("iir", `UFC_IIR_XOFF, iir_q);
      cmp8("rxo", 8'h17, rxo_data);
      sendc(8'h66);
      @(posedge core_clk);
      iir_rd <= 1'b1;
      @(posedge core_clk);
      iir_rd <= 1'b0;
      tick(2);
      cmp8("iir", `UFC_RST_IIR, iir_q);
      pop;
    end
  endtask
  task s_xany;
    begin
      cfg(`UFC_SEL_EFR, 8'h02);
      cfg(`UFC_SEL_MCR, 8'h20);
      rxc(8'h13);
      rxc(8'h41);
      tick(3);
      cmp8("rxo", 8'h41, rxo_data);
      sendc(8'h77);
      pop;
      cfg(`UFC_SEL_MCR, 8'h00);
      rxc(8'h11);
    end
  endtask
  // inserted chars cut to five bits, far side stalling
  task s_ins;
    begin
      cfg(`UFC_SEL_LCR, 8'h00);
      cfg(`UFC_SEL_HALT_CHAR_FIRST, 8'hf3);
      cfg(`UFC_SEL_RESUME_CHAR_FIRST, 8'he1);
      cfg(`UFC_SEL_HALT_CHAR_SECOND, 8'hd7);
      cfg(`UFC_SEL_RESUME_CHAR_SECOND, 8'hc5);
      cfg(`UFC_SEL_TCR, 8'h13);
      slow <= 1'b1;
      for (m = 1; m < 4; m = m + 1) begin
        cfg(`UFC_SEL_EFR, {4'h0, m[1:0], 2'h0});
        b = n_q;
        rx_level <= 7'h04;
        waitn(b + ((m == 3) ? 8'h02 : 8'h01));
        cmp8("xoff", (m == 2) ? 8'h13 : 8'h17, got_q);
        b = n_q;
        rx_level <= 7'h00;
        waitn(b + ((m == 3) ? 8'h02 : 8'h01));
        cmp8("xon", (m == 2) ? 8'h01 : 8'h05, got_q);
      end
      cfg(`UFC_SEL_EFR, 8'h00);
      b = n_q;
      rx_level <= 7'h04;
      tick(12);
      cmp8("count", b, n_q);
      rx_level <= 7'h00;
      slow <= 1'b0;
      cfg(`UFC_SEL_LCR, 8'h03);
    end
  endtask
  task s_cts;
    begin
      cfg(`UFC_SEL_EFR, 8'h80);
      cts_hold <= 1'b1;
      tick(5);
      tx_in_valid <= 1'b1;
      tx_in_data <= 8'h99;
      nordy;
      cmp8("iir", `UFC_RST_IIR, iir_q);
      cts_hold <= 1'b0;
      sendc(8'h99);
    end
  endtask
  // reset for eight cycles, then every scenario in turn
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    s_reset;
    s_rts;
    s_fifo;
    s_xoff;
    s_spec;
    s_xany;
    s_ins;
    s_cts;
    conclude;
  end
endmodule // testbench

// file: dv/ufc_flow_sva.sv
// checker on the ports of the flow-control top
`timescale 1ns/1ns
module ufc_flow_sva #(
  parameter LVLW = 7
) (
  input wire            core_clk,
  input wire            rst,
  input wire            cfg_wr,
  input wire [3:0]      cfg_sel,
  input wire [7:0]      cfg_data,
  input wire [LVLW-1:0] rx_level,
  input wire            cts_n_pin,
  input wire            rts_n_q,
  input wire            rx_valid,
  input wire            rx_ready,
  input wire [7:0]      rx_data,
  input wire            tx_in_ready_q,
  input wire            irq_q,
  input wire [7:0]      iir_q
);
  reg  [7:0]      efr_q;
  reg  [7:0]      tcr_q;
  reg  [7:0]      mcr_q;
  reg  [7:0]      xoff_q;
  wire [LVLW-1:0] rhi = {{(LVLW-4){1'b0}}, tcr_q[3:0]};
  wire [LVLW-1:0] rlo = {{(LVLW-4){1'b0}}, tcr_q[7:4]};
  // shadow of the written controls, cleared like the real ones
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      efr_q <= 8'h00;
      tcr_q <= 8'h00;
      mcr_q <= 8'h00;
    end else if (cfg_wr) begin
      if (cfg_sel == 4'h0) efr_q <= cfg_data;
      if (cfg_sel == 4'h1) tcr_q <= cfg_data;
      if (cfg_sel == 4'h2) mcr_q <= cfg_data;
    end
  end
  // flow characters outlive reset, so no reset branch
  always @(posedge core_clk) begin
    if (cfg_wr && cfg_sel == 4'h8) xoff_q <= cfg_data;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // four cycles of margin cover the rts_act_q and rts_n_q flops
  chk_rts_halt: assert property (
    (efr_q[6] && rlo < rhi && rx_level >= rhi && $stable(tcr_q)) [*4]
    |-> rts_n_q) else $error("rts kept at halt level");
  chk_rts_resume: assert property (
    (efr_q[6] && rlo < rhi && rx_level <= rlo && $stable(tcr_q)) [*4]
    |-> !rts_n_q) else $error("rts not back at resume level");
  chk_rts_manual: assert property (
    (!efr_q[6] && $stable(mcr_q)) [*4] |-> rts_n_q == !mcr_q[1])
    else $error("rts ignores modem control");
  chk_cts_gate: assert property (
    (efr_q[7] && cts_n_pin) [*5] |-> !tx_in_ready_q)
    else $error("byte taken while cts inactive");
  chk_tx_pulse: assert property (
    tx_in_ready_q |=> !tx_in_ready_q) else $error("tx ready too long");
  chk_cts_quiet: assert property (
    efr_q[7] [*3] |-> iir_q != 8'h20) else $error("cts change flagged");
  chk_irq_cause: assert property (
    irq_q |-> iir_q == 8'h10 || iir_q == 8'h20)
    else $error("irq without cause");
  chk_xoff_halt: assert property (
    (efr_q[1:0] == 2'h2 && !mcr_q[5] && rx_valid && rx_ready
     && rx_data == xoff_q) |-> ##3 !tx_in_ready_q [*3])
    else $error("tx taken after xoff");
endmodule // ufc_flow_sva
bind ufc_flow ufc_flow_sva #(.LVLW(LVLW)) u_sva (
  .core_clk(core_clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
  .cfg_data(cfg_data), .rx_level(rx_level), .cts_n_pin(cts_n_pin),
  .rts_n_q(rts_n_q), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .rx_data(rx_data), .tx_in_ready_q(tx_in_ready_q), .irq_q(irq_q),
  .iir_q(iir_q));

// file: dv/ufc_remote.sv
// far-side model: remote uart taking bytes, driving clear-to-send
`timescale 1ns/1ns
module ufc_remote (
  input  wire       core_clk,
  input  wire       rst,
  input  wire       slow,
  input  wire       cts_hold,
  input  wire       tx_out_valid_q,
  input  wire [7:0] tx_out_data_q,
  output reg        tx_out_ready,
  output wire       cts_n_pin,
  output reg  [7:0] got_q,
  output reg  [7:0] n_q
);
  reg [1:0] wait_q;
  // remote stops us by holding cts high well before a stop bit
  assign cts_n_pin = cts_hold;
  // take a byte at once or after a stall of a few cycles
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_out_ready <= 1'b0;
      wait_q <= 2'h0;
      got_q <= 8'h00;
      n_q <= 8'h00;
    end else if (tx_out_valid_q && !tx_out_ready) begin
      wait_q <= wait_q + 2'h1;
      if (wait_q == (slow ? 2'h3 : 2'h0)) begin
        tx_out_ready <= 1'b1;
        got_q <= tx_out_data_q;
        n_q <= n_q + 8'h01;
      end
    end else begin
      tx_out_ready <= 1'b0;
      wait_q <= 2'h0;
    end
  end
endmodule // ufc_remote

// file: logic/ufc_flow.v
// uart flow control: rts/cts automation, xon/xoff matching and insertion
`timescale 1ns/1ns
`include "ufc_map.vh"
// Notes on behaviour
// - auto rts: active once level falls to resume, until level reaches halt
// - level reaching halt drops rts
// - rts returns when level falls to resume
// - bytes still accepted after rts drop until the rx fifo is full
// - auto cts: byte starts only with cts active; inserted xon/xoff chars are sent without checking cts
// - no cts change interrupt under auto cts
// - auto cts and rts enabled separately
// - tx pair select: none, first, second, both
// - rx pair select: none, first, second, both
// - xon any: any char but xoff after xoff resumes
// - special char flags, stores, never halts
// - xoff halts after current character
// - xoff flag drives interrupt when enabled
// - xon clears flag and resumes transmit
// - send xoff once level passes halt
// - send xon when level reaches resume
// - inserted chars cut to word length
// - characters and scratch survive reset
// - reset loads documented register values

// ---------------------------------------------------------------
// small fifo with registered valid and ready
// ---------------------------------------------------------------
module ufc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             core_clk,
  input  wire             rst,
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  output reg              out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  reg [AW:0]      cnt_d;
  wire            push;
  wire            pop;

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign out_data = mem[rd_q];

  // storage has no reset; pointers guard it
  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always @* begin
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // flags computed from next count so they stay honest
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_q      <= {AW{1'b0}};
      rd_q      <= {AW{1'b0}};
      cnt_q     <= {(AW+1){1'b0}};
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q     <= cnt_d;
      in_ready  <= (cnt_d != DEPTH[AW:0]);
      out_valid <= (cnt_d != {(AW+1){1'b0}});
    end
  end
endmodule // ufc_fifo

// ---------------------------------------------------------------
// flow-control top
// ---------------------------------------------------------------
module ufc_flow #(
  parameter LVLW = 7
) (
  input  wire            core_clk,
  input  wire            rst,
  input  wire            cfg_wr,
  input  wire [3:0]      cfg_sel,
  input  wire [7:0]      cfg_data,
  input  wire            iir_rd,
  input  wire            msr_rd,
  input  wire [LVLW-1:0] rx_level,
  input  wire            cts_n_pin,
  input  wire [2:0]      modem_n_pin,
  output reg             rts_n_q,
  input  wire            rx_valid,
  output wire            rx_ready,
  input  wire [7:0]      rx_data,
  output wire            rxo_valid,
  input  wire            rxo_ready,
  output wire [7:0]      rxo_data,
  input  wire            tx_in_valid,
  output reg             tx_in_ready_q,
  input  wire [7:0]      tx_in_data,
  output reg             tx_out_valid_q,
  input  wire            tx_out_ready,
  output reg  [7:0]      tx_out_data_q,
  output reg             irq_q,
  output reg  [7:0]      iir_q,
  output reg  [7:0]      lsr_q,
  output reg  [7:0]      msr_q,
  output reg  [7:0]      scratch_q
);
  // programmed registers
  reg [7:0] efr_q, tcr_q, mcr_q, ier_q, lcr_q;
  reg [7:0] resume_char_first_q, resume_char_second_q, halt_char_first_q, halt_char_second_q;
  // pin synchronisers: first stage read only by the second
  reg [3:0] pin_s1_q, pin_s2_q, pin_last_q;
  // flow state
  reg       halt_q, xflag_q, xspec_q, ctsrts_q, rts_act_q;
  reg       sent_off_q, ins_off_q, after_on1_q, after_off1_q;
  reg [1:0] ins_pend_q;
  reg       fifo_push;
  reg       det_off, det_on, det_spec, any_resume;

  wire       cts_act  = ~pin_s2_q[0];
  wire       acts     = efr_q[`UFC_EFR_ACTS];
  wire       arts     = efr_q[`UFC_EFR_ARTS];
  wire [1:0] txm      = efr_q[`UFC_EFR_TX];
  wire [1:0] rxm      = efr_q[`UFC_EFR_RX];
  wire [3:0] halt_lv  = tcr_q[`UFC_TCR_HALT];
  wire [3:0] res_lv   = tcr_q[`UFC_TCR_RESUME];
  wire       rx_take  = rx_valid & rx_ready;
  wire       above_ht = rx_level >= {{(LVLW-4){1'b0}}, halt_lv};
  wire       at_res   = rx_level <= {{(LVLW-4){1'b0}}, res_lv};

  // cut an inserted character to the programmed word length
  function [7:0] wl_mask;
    input [7:0] ch;
    input [1:0] wl;
    begin
      wl_mask = ch & (8'hff >> (2'h3 - wl));
    end
  endfunction

  // ---------------------------------------------------------------
  // programmed registers
  // ---------------------------------------------------------------
  // control registers take their reset values
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      efr_q <= `UFC_RST_ZERO;
      tcr_q <= `UFC_RST_ZERO;
      mcr_q <= `UFC_RST_ZERO;
      ier_q <= `UFC_RST_ZERO;
      lcr_q <= `UFC_RST_LCR;
    end else if (cfg_wr) begin
      case (cfg_sel)
        `UFC_SEL_EFR: efr_q <= cfg_data;
        `UFC_SEL_TCR: tcr_q <= cfg_data;
        `UFC_SEL_MCR: mcr_q <= cfg_data;
        `UFC_SEL_IER: ier_q <= cfg_data;
        `UFC_SEL_LCR: lcr_q <= cfg_data;
        default: ;
      endcase
    end
  end

  // characters and scratch have no reset at all
  always @(posedge core_clk) begin
    if (cfg_wr) begin
      case (cfg_sel)
        `UFC_SEL_SCR:   scratch_q <= cfg_data;
        `UFC_SEL_RESUME_CHAR_FIRST:  resume_char_first_q    <= cfg_data;
        `UFC_SEL_RESUME_CHAR_SECOND:  resume_char_second_q    <= cfg_data;
        `UFC_SEL_HALT_CHAR_FIRST: halt_char_first_q   <= cfg_data;
        `UFC_SEL_HALT_CHAR_SECOND: halt_char_second_q   <= cfg_data;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // receive matching
  // ---------------------------------------------------------------
  always @* begin
    det_off  = 1'b0;
    det_on   = 1'b0;
    det_spec = 1'b0;
    case (rxm)
      `UFC_PAIR_FIRST: begin
        det_off = rx_data == halt_char_first_q;
        det_on  = rx_data == resume_char_first_q;
      end
      `UFC_PAIR_SECOND: begin
        det_off = rx_data == halt_char_second_q;
        det_on  = rx_data == resume_char_second_q;
      end
      `UFC_PAIR_BOTH: begin
        det_off = after_off1_q & (rx_data == halt_char_second_q);
        det_on  = after_on1_q & (rx_data == resume_char_second_q);
      end
      default: ;
    endcase
    det_spec   = efr_q[`UFC_EFR_SPEC] & (rx_data == halt_char_second_q) & ~det_off;
    any_resume = halt_q & mcr_q[`UFC_MCR_XANY] & ~det_off;
    // flow characters are consumed, special and others are stored
    fifo_push  = rx_take & ~det_off & ~det_on;
  end

  ufc_fifo #(
    .WIDTH (8),
    .DEPTH (4),
    .AW    (2)
  ) u_rx_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (rx_valid & ~(det_off | det_on)),
    .in_ready  (rx_ready),
    .in_data   (rx_data),
    .out_valid (rxo_valid),
    .out_ready (rxo_ready),
    .out_data  (rxo_data)
  );

  // halt state and xoff flag; a set wins over a read clear
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      halt_q       <= 1'b0;
      xflag_q      <= 1'b0;
      xspec_q      <= 1'b0;
      after_on1_q  <= 1'b0;
      after_off1_q <= 1'b0;
    end else begin
      if (rx_take) begin
        after_on1_q  <= rx_data == resume_char_first_q;
        after_off1_q <= rx_data == halt_char_first_q;
        if (det_off) begin
          halt_q  <= 1'b1;
          xflag_q <= 1'b1;
          xspec_q <= 1'b0;
        end else if (det_on | any_resume) begin
          halt_q <= 1'b0;
          if (!xspec_q) xflag_q <= 1'b0;
        end
        if (det_spec) begin
          xflag_q <= 1'b1;
          xspec_q <= 1'b1;
        end
      end
      if (iir_rd && xspec_q && !(rx_take && (det_spec || det_off))) begin
        xflag_q <= 1'b0;
        xspec_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // rts and pins
  // ---------------------------------------------------------------
  // rts hysteresis; receive path refuses any byte only when its fifo is full, regardless of rts
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rts_act_q  <= 1'b0;
      rts_n_q    <= 1'b1;
      pin_s1_q   <= 4'hf;
      pin_s2_q   <= 4'hf;
      pin_last_q <= 4'hf;
    end else begin
      pin_s1_q   <= {modem_n_pin, cts_n_pin};
      pin_s2_q   <= pin_s1_q;
      pin_last_q <= pin_s2_q;
      if (above_ht) rts_act_q <= 1'b0;
      else if (at_res || rts_act_q) rts_act_q <= 1'b1;
      if (arts) rts_n_q <= ~(rts_act_q & ~above_ht);
      else rts_n_q <= ~mcr_q[`UFC_MCR_RTS];
    end
  end

  // ---------------------------------------------------------------
  // transmit gating and xon/xoff insertion
  // ---------------------------------------------------------------
  wire slot_free = ~tx_out_valid_q | tx_out_ready;
  wire cts_ok    = ~acts | cts_act;
  wire data_ok   = ~halt_q & cts_ok & (ins_pend_q == 2'h0);
  wire [7:0] ins_char = ins_off_q ?
                        (ins_pend_q[1] ? halt_char_first_q : halt_char_second_q) :
                        (ins_pend_q[1] ? resume_char_first_q : resume_char_second_q);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_in_ready_q  <= 1'b0;
      tx_out_valid_q <= 1'b0;
      tx_out_data_q  <= `UFC_RST_ZERO;
      ins_pend_q     <= 2'h0;
      ins_off_q      <= 1'b0;
      sent_off_q     <= 1'b0;
    end else begin
      if (tx_out_valid_q && tx_out_ready) tx_out_valid_q <= 1'b0;
      // queue one char per selected pair when the level crosses a threshold
      if (ins_pend_q == 2'h0 && txm != `UFC_PAIR_NONE) begin
        if (!sent_off_q && rx_level > {{(LVLW-4){1'b0}}, halt_lv}) begin
          ins_pend_q <= {txm[1], txm[0]};
          ins_off_q  <= 1'b1;
          sent_off_q <= 1'b1;
        end else if (sent_off_q && at_res) begin
          ins_pend_q <= {txm[1], txm[0]};
          ins_off_q  <= 1'b0;
          sent_off_q <= 1'b0;
        end
      end
      // inserted characters take the slot before tx_in_data unless a byte was already granted
      tx_in_ready_q <= 1'b0;
      if (ins_pend_q != 2'h0 && slot_free && !tx_in_ready_q) begin
        tx_out_valid_q <= 1'b1;
        tx_out_data_q  <= wl_mask(ins_char, lcr_q[`UFC_LCR_WLEN]);
        if (ins_pend_q[1]) ins_pend_q[1] <= 1'b0;
        else ins_pend_q[0] <= 1'b0;
      end else if (tx_in_ready_q && tx_in_valid) begin
        tx_out_valid_q <= 1'b1;
        tx_out_data_q  <= tx_in_data;
      end else if (tx_in_valid && slot_free && data_ok) begin
        tx_in_ready_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt identification and status
  // ---------------------------------------------------------------
  wire cts_rise = pin_s2_q[0] & ~pin_last_q[0];
  // edge, not level: rts active now and about to go inactive
  wire rts_rise = arts & ~rts_n_q & ~(rts_act_q & ~above_ht);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctsrts_q <= 1'b0;
      irq_q    <= 1'b0;
      iir_q    <= `UFC_RST_IIR;
      lsr_q    <= `UFC_RST_LSR;
      msr_q    <= `UFC_RST_ZERO;
    end else begin
      if ((cts_rise && !acts) || rts_rise) ctsrts_q <= 1'b1;
      else if (iir_rd) ctsrts_q <= 1'b0;
      if (xflag_q && ier_q[`UFC_IER_XOFF]) iir_q <= `UFC_IIR_XOFF;
      else if (ctsrts_q && ier_q[`UFC_IER_CTSRTS]) iir_q <= `UFC_IIR_CTSRTS;
      else iir_q <= `UFC_RST_IIR;
      irq_q <= (xflag_q & ier_q[`UFC_IER_XOFF]) |
               (ctsrts_q & ier_q[`UFC_IER_CTSRTS]);
      lsr_q <= {1'b0, ~tx_out_valid_q, ~tx_out_valid_q, 4'h0, rxo_valid};
      msr_q[7:4] <= ~pin_s2_q;
      msr_q[3:0] <= (pin_s2_q ^ pin_last_q) | (msr_rd ? 4'h0 : msr_q[3:0]);
    end
  end
endmodule // ufc_flow

// file: logic/ufc_map.vh
// constants for the uart flow-control block
`ifndef UFC_MAP_VH
`define UFC_MAP_VH
// ---------------------------------------------------------------
// configuration write selects
// ---------------------------------------------------------------
`define UFC_SEL_EFR      4'h0
`define UFC_SEL_TCR      4'h1
`define UFC_SEL_MCR      4'h2
`define UFC_SEL_IER      4'h3
`define UFC_SEL_LCR      4'h4
`define UFC_SEL_SCR      4'h5
`define UFC_SEL_RESUME_CHAR_FIRST     4'h6
`define UFC_SEL_RESUME_CHAR_SECOND     4'h7
`define UFC_SEL_HALT_CHAR_FIRST    4'h8
`define UFC_SEL_HALT_CHAR_SECOND    4'h9
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define UFC_EFR_ACTS     7
`define UFC_EFR_ARTS     6
`define UFC_EFR_SPEC     5
`define UFC_EFR_TX       3:2
`define UFC_EFR_RX       1:0
`define UFC_TCR_HALT     3:0
`define UFC_TCR_RESUME   7:4
`define UFC_MCR_XANY     5
`define UFC_MCR_RTS      1
`define UFC_IER_XOFF     5
`define UFC_IER_CTSRTS   7
`define UFC_LCR_WLEN     1:0
// ---------------------------------------------------------------
// pair selections for tx and rx software flow control
// ---------------------------------------------------------------
`define UFC_PAIR_NONE    2'h0
`define UFC_PAIR_SECOND  2'h1
`define UFC_PAIR_FIRST   2'h2
`define UFC_PAIR_BOTH    2'h3
// ---------------------------------------------------------------
// reset values and interrupt identification codes
// ---------------------------------------------------------------
`define UFC_RST_ZERO     8'h00
`define UFC_RST_LCR      8'h1d
`define UFC_RST_IIR      8'h01
`define UFC_RST_LSR      8'h60
`define UFC_IIR_XOFF     8'h10
`define UFC_IIR_CTSRTS   8'h20
`endif
